// ==== bsl_defines.svh ====
`ifndef BSL_DEFINES_SVH
`define BSL_DEFINES_SVH
// Clock rates
`define BSL_CORE_HZ 100000000
`define BSL_SCK_HZ 12000000
// Core cycles per serial clock half period, rounded up so the clock never exceeds its rate
`define BSL_HALF_CYC ((`BSL_CORE_HZ + 2 * `BSL_SCK_HZ - 1) / (2 * `BSL_SCK_HZ))
// Strap ratio thresholds in hundredths
`define BSL_DIV_010 8'h0A
`define BSL_DIV_020 8'h14
`define BSL_DIV_030 8'h1E
`define BSL_DIV_040 8'h28
`define BSL_DIV_050 8'h32
`define BSL_DIV_060 8'h3C
`define BSL_DIV_070 8'h46
`define BSL_DIV_080 8'h50
`define BSL_DIV_090 8'h5A
// Flash read command and image length
`define BSL_CMD_READ 8'h03
`define BSL_IMAGE_BYTES 17'h10000
`define BSL_FRAME_BITS 6'h20
`endif

// ==== bsl_flash_model.sv ====
`timescale 1ns/1ps
// ----------
// Serial flash seen from the loader
// ----------
module bsl_flash_model (
  input wire logic flash_sclk,
  input wire logic flash_cs_n,
  input wire logic flash_data_out,
  input wire logic strap_level,
  input wire logic [7:0] key,
  output logic flash_data_in,
  output logic [31:0] cmd_word
);
  // capacity and erase sector of the part
  localparam int MEM_BYTES = 65536;
  localparam int SECTOR_BYTES = 4096;
  int rise_count = 0;
  int bit_pos;
  int byte_idx;
  logic drive_en = 1'b0;
  logic drive_bit = 1'b0;
  logic [7:0] value;
  // Released line falls back to the strap resistor level
  assign flash_data_in = drive_en ? drive_bit : strap_level;
  always @(negedge flash_cs_n) begin
    rise_count <= 0;
  end
  always @(posedge flash_cs_n) begin
    drive_en <= 1'b0;
  end
  // command captured on rising edge, any clock rate
  always @(posedge flash_sclk) begin
    if (!flash_cs_n) begin
      if (rise_count < 32) begin
        cmd_word <= {cmd_word[30:0], flash_data_out};
      end
      rise_count <= rise_count + 1;
    end
  end
  // data shifted on falling edge, address wraps at capacity
  always @(negedge flash_sclk) begin
    if (!flash_cs_n && rise_count >= 32) begin
      bit_pos = rise_count - 32;
      byte_idx = (int'(cmd_word[23:0]) + bit_pos / 8) % MEM_BYTES;
      value = key + 8'(byte_idx * 3);
      drive_bit <= value[7 - bit_pos % 8];
      drive_en <= 1'b1;
    end
  end
endmodule

// ==== bsl_loader.sv ====
`timescale 1ns/1ps
`include "bsl_defines.svh"
module bsl_loader (
  input wire logic clock,
  input wire logic rstn,
  input wire logic slow_clock,
  input wire logic [7:0] boot_strap_divider_input,
  input wire logic divider_valid,
  input wire logic bus_powered,
  input wire logic aux_supply_3v3,
  input wire logic flash_data_in,
  input wire logic [7:0] image_last_byte,
  input wire logic load_ok,
  output logic flash_sclk,
  output logic flash_cs_n,
  output logic flash_data_out,
  output logic [7:0] load_data,
  output logic load_valid,
  output logic internal_switch_en,
  output logic external_switch_en,
  output logic ports_enabled,
  output logic legacy_sink,
  output logic boot_done,
  output logic in_boot,
  output bsl_pkg::bsl_db_mode_t db_mode,
  output bsl_pkg::bsl_cfg_t fallback_cfg,
  output logic [15:0] slow_tick_count
);
  import bsl_pkg::*;

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  logic [1:0] miso_sync_reg;
  logic [1:0] aux_sync_reg;
  logic [1:0] vbus_sync_reg;
  logic [1:0] dv_sync_reg;
  always_ff @(posedge clock) begin
    miso_sync_reg <= {miso_sync_reg[0], flash_data_in};
    aux_sync_reg <= {aux_sync_reg[0], aux_supply_3v3};
    vbus_sync_reg <= {vbus_sync_reg[0], bus_powered};
    dv_sync_reg <= {dv_sync_reg[0], divider_valid};
  end
  wire miso_s = miso_sync_reg[1];
  wire aux_s = aux_sync_reg[1];
  wire vbus_s = vbus_sync_reg[1];

  // ------------------------------------------------------------
  // Slow timer domain
  // ------------------------------------------------------------
  // slow timer
  logic [15:0] slow_cnt_reg;
  logic [15:0] slow_gray_reg;
  logic [1:0] slow_rst_reg;
  // Gray code so the count crosses as a multi-bit word safely
  wire [15:0] slow_gray = slow_cnt_reg ^ (slow_cnt_reg >> 1);
  always_ff @(posedge slow_clock) begin
    slow_rst_reg <= {slow_rst_reg[0], rstn};
    if (!slow_rst_reg[1]) begin
      slow_cnt_reg <= 16'h0000;
      slow_gray_reg <= 16'h0000;
    end else begin
      slow_cnt_reg <= slow_cnt_reg + 16'h0001;
      // Registered so no decode glitch reaches the other domain
      slow_gray_reg <= slow_gray;
    end
  end
  logic [15:0] gray_s1_reg;
  logic [15:0] gray_s2_reg;
  always_ff @(posedge clock) begin
    gray_s1_reg <= slow_gray_reg;
    gray_s2_reg <= gray_s1_reg;
  end
  logic [15:0] bin_dec;
  always_comb begin
    bin_dec[15] = gray_s2_reg[15];
    for (int i = 14; i >= 0; i--) begin
      bin_dec[i] = bin_dec[i + 1] ^ gray_s2_reg[i];
    end
  end
  logic [15:0] tick_reg;
  always_ff @(posedge clock) begin
    tick_reg <= bin_dec;
  end

  // ------------------------------------------------------------
  // Strap decode
  // ------------------------------------------------------------
  wire [7:0] d = boot_strap_divider_input;
  bsl_db_mode_t mode_hi;
  bsl_db_mode_t mode_lo;
  bsl_cfg_t cfg_lo;
  assign mode_hi = (d < `BSL_DIV_020) ? BSL_DB_NO_RESPONSE :
                   (d < `BSL_DIV_030) ? BSL_DB_WAIT_INT :
                   (d < `BSL_DIV_040) ? BSL_DB_RETRY_INT :
                   (d < `BSL_DIV_050) ? BSL_DB_WAIT_EXT :
                   (d < `BSL_DIV_060) ? BSL_DB_RETRY_EXT : BSL_DB_CONTINUE;
  assign mode_lo = (d < `BSL_DIV_020) ? BSL_DB_NO_RESPONSE :
                   (d < `BSL_DIV_030) ? BSL_DB_CONTINUE :
                   (d < `BSL_DIV_040) ? BSL_DB_RETRY_INT :
                   (d < `BSL_DIV_050) ? BSL_DB_CONTINUE :
                   (d < `BSL_DIV_060) ? BSL_DB_RETRY_EXT :
                   (d < `BSL_DIV_080) ? BSL_DB_CONTINUE :
                   (d < `BSL_DIV_090) ? BSL_DB_NO_RESPONSE : BSL_DB_CONTINUE;
  assign cfg_lo = (d < `BSL_DIV_010) ? BSL_CFG_RESERVED :
                  (d < `BSL_DIV_020) ? BSL_CFG_1 :
                  (d < `BSL_DIV_030) ? BSL_CFG_2 :
                  (d < `BSL_DIV_040) ? BSL_CFG_INFINITE :
                  (d < `BSL_DIV_050) ? BSL_CFG_3 :
                  (d < `BSL_DIV_060) ? BSL_CFG_INFINITE :
                  (d < `BSL_DIV_070) ? BSL_CFG_4 :
                  (d < `BSL_DIV_090) ? BSL_CFG_RESERVED : BSL_CFG_5;
  wire retry_hi = (mode_hi == BSL_DB_RETRY_INT) || (mode_hi == BSL_DB_RETRY_EXT);
  wire bsl_db_mode_t mode_sel = miso_s ? mode_hi : mode_lo;
  wire bsl_cfg_t cfg_sel = miso_s ? (retry_hi ? BSL_CFG_INFINITE : BSL_CFG_SAFE) : cfg_lo;

  // ------------------------------------------------------------
  // Boot sequencer
  // ------------------------------------------------------------
  bsl_state_t state_reg, state_next;
  bsl_db_mode_t mode_reg;
  bsl_cfg_t cfg_reg;
  logic loaded_reg;
  logic [7:0] hcnt_reg;
  logic [5:0] bit_reg;
  logic [16:0] byte_reg;
  logic [31:0] sh_reg;
  logic [7:0] rx_reg;
  logic sclk_reg;
  logic cs_n_reg;
  logic [7:0] data_reg;
  logic valid_reg;

  wire is_retry = (mode_reg == BSL_DB_RETRY_INT) || (mode_reg == BSL_DB_RETRY_EXT);
  wire is_wait = (mode_reg == BSL_DB_WAIT_INT) || (mode_reg == BSL_DB_WAIT_EXT);
  wire hold_for_supply = vbus_s && !aux_s && (is_wait || mode_reg == BSL_DB_NO_RESPONSE);
  wire half_done = (hcnt_reg == 8'(`BSL_HALF_CYC - 1));
  wire fall_edge = half_done && sclk_reg;
  wire rise_edge = half_done && !sclk_reg;
  wire frame_end = fall_edge && (bit_reg == 6'h00);
  // Load failed: retry modes and infinite wait try again forever
  wire keep_trying = is_retry || (cfg_reg == BSL_CFG_INFINITE);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      BSL_ST_INIT: state_next = BSL_ST_STRAP;
      BSL_ST_STRAP: if (dv_sync_reg[1]) state_next = BSL_ST_WAIT_SUPPLY;
      BSL_ST_WAIT_SUPPLY: if (!hold_for_supply) state_next = BSL_ST_LOAD;
      BSL_ST_LOAD: state_next = BSL_ST_SHIFT;
      BSL_ST_SHIFT: if (frame_end && byte_reg == 17'h00000) state_next = BSL_ST_CHECK;
      BSL_ST_CHECK: begin
        if (load_ok) state_next = BSL_ST_DONE;
        else if (keep_trying) state_next = BSL_ST_LOAD;
        else state_next = BSL_ST_DONE;
      end
      BSL_ST_DONE: state_next = BSL_ST_DONE;
      default: state_next = BSL_ST_INIT;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      state_reg <= BSL_ST_INIT;
      mode_reg <= BSL_DB_NO_RESPONSE;
      cfg_reg <= BSL_CFG_SAFE;
      loaded_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (state_reg == BSL_ST_STRAP && dv_sync_reg[1]) begin
        mode_reg <= mode_sel;
        cfg_reg <= cfg_sel;
      end
      if (state_reg == BSL_ST_CHECK) begin
        loaded_reg <= load_ok;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      hcnt_reg <= 8'h00;
      bit_reg <= 6'h00;
      byte_reg <= 17'h00000;
      sh_reg <= 32'h00000000;
      rx_reg <= 8'h00;
      sclk_reg <= 1'b0;
      cs_n_reg <= 1'b1;
      valid_reg <= 1'b0;
      data_reg <= 8'h00;
    end else begin
      valid_reg <= 1'b0;
      if (state_reg == BSL_ST_LOAD) begin
        cs_n_reg <= 1'b0;
        sh_reg <= {`BSL_CMD_READ, 24'h000000};
        bit_reg <= 6'(`BSL_FRAME_BITS - 1);
        byte_reg <= `BSL_IMAGE_BYTES;
        hcnt_reg <= 8'h00;
        sclk_reg <= 1'b0;
      end else if (state_reg == BSL_ST_SHIFT) begin
        hcnt_reg <= half_done ? 8'h00 : hcnt_reg + 8'h01;
        if (half_done) sclk_reg <= !sclk_reg;
        if (rise_edge) rx_reg <= {rx_reg[6:0], miso_s};
        if (fall_edge) begin
          sh_reg <= {sh_reg[30:0], 1'b0};
          if (bit_reg != 6'h00) begin
            bit_reg <= bit_reg - 6'h01;
          end else begin
            bit_reg <= 6'h07;
            if (byte_reg != `BSL_IMAGE_BYTES) begin
              data_reg <= rx_reg;
              valid_reg <= 1'b1;
            end
            byte_reg <= byte_reg - 17'h00001;
            if (byte_reg == 17'h00000) cs_n_reg <= 1'b1;
          end
        end
      end else begin
        sclk_reg <= 1'b0;
        cs_n_reg <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // Outputs and power path
  // ------------------------------------------------------------
  assign flash_sclk = sclk_reg;
  assign flash_cs_n = cs_n_reg;
  assign flash_data_out = sh_reg[31];
  assign load_data = data_reg;
  assign load_valid = valid_reg;
  wire strapped = (state_reg != BSL_ST_INIT) && (state_reg != BSL_ST_STRAP);
  wire use_int = (mode_reg == BSL_DB_WAIT_INT) || (mode_reg == BSL_DB_RETRY_INT);
  wire use_ext = (mode_reg == BSL_DB_WAIT_EXT) || (mode_reg == BSL_DB_RETRY_EXT);
  wire cfg_ext = (cfg_reg == BSL_CFG_4) || (cfg_reg == BSL_CFG_5);
  wire cont_done = (mode_reg == BSL_DB_CONTINUE) && boot_done && loaded_reg;
  assign internal_switch_en = vbus_s && strapped && (use_int || (cont_done && !cfg_ext));
  assign external_switch_en = vbus_s && strapped && (use_ext || (cont_done && cfg_ext));
  assign boot_done = (state_reg == BSL_ST_DONE);
  assign in_boot = !boot_done;
  assign ports_enabled = boot_done && (loaded_reg || cfg_reg != BSL_CFG_SAFE);
  assign legacy_sink = boot_done && !loaded_reg && cfg_reg == BSL_CFG_SAFE && vbus_s;
  assign db_mode = mode_reg;
  assign fallback_cfg = cfg_reg;
  assign slow_tick_count = tick_reg;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  a_sclk_idle_low: assert property (cs_n_reg |-> !sclk_reg) else $error("clock not low while idle");
  a_cs_first_bit: assert property ($fell(cs_n_reg) |-> sh_reg[31] == 1'b0 && !sclk_reg) else $error("bad first bit");
  a_data_on_fall: assert property ($changed(sh_reg) && !$fell(cs_n_reg) |-> $fell(sclk_reg)) else $error("data moved off falling edge");
  a_no_resp_off: assert property (mode_reg == BSL_DB_NO_RESPONSE |-> !internal_switch_en && !external_switch_en) else $error("switch on in no-response");
  a_wait_holds: assert property (state_reg == BSL_ST_WAIT_SUPPLY && hold_for_supply |=> state_reg == BSL_ST_WAIT_SUPPLY) else $error("start-up without supply");
  a_retry_again: assert property (state_reg == BSL_ST_CHECK && !load_ok && is_retry |=> state_reg == BSL_ST_LOAD) else $error("retry stopped");
  a_cont_after: assert property (mode_reg == BSL_DB_CONTINUE && !boot_done |-> !internal_switch_en && !external_switch_en) else $error("switch before load");
  a_strap_stable: assert property (strapped |=> $stable(mode_reg) && $stable(cfg_reg)) else $error("strap changed");
  a_init_first: assert property ($rose(rstn) |-> state_reg == BSL_ST_INIT) else $error("no init");
  c_load_done: cover property (state_reg == BSL_ST_CHECK ##1 boot_done);
  c_retry: cover property (state_reg == BSL_ST_CHECK ##1 state_reg == BSL_ST_LOAD);
  c_wait: cover property (state_reg == BSL_ST_WAIT_SUPPLY [*3]);
endmodule

// ==== bsl_pkg.sv ====
package bsl_pkg;
  typedef enum logic [2:0] {
    BSL_DB_NO_RESPONSE = 3'h0,
    BSL_DB_WAIT_INT = 3'h1,
    BSL_DB_WAIT_EXT = 3'h2,
    BSL_DB_RETRY_INT = 3'h3,
    BSL_DB_RETRY_EXT = 3'h4,
    BSL_DB_CONTINUE = 3'h5
  } bsl_db_mode_t;
  typedef enum logic [2:0] {
    BSL_CFG_SAFE = 3'h0,
    BSL_CFG_INFINITE = 3'h1,
    BSL_CFG_1 = 3'h2,
    BSL_CFG_2 = 3'h3,
    BSL_CFG_3 = 3'h4,
    BSL_CFG_4 = 3'h5,
    BSL_CFG_5 = 3'h6,
    BSL_CFG_RESERVED = 3'h7
  } bsl_cfg_t;
  typedef enum logic [6:0] {
    BSL_ST_INIT = 7'h01,
    BSL_ST_STRAP = 7'h02,
    BSL_ST_WAIT_SUPPLY = 7'h04,
    BSL_ST_LOAD = 7'h08,
    BSL_ST_SHIFT = 7'h10,
    BSL_ST_CHECK = 7'h20,
    BSL_ST_DONE = 7'h40
  } bsl_state_t;
endpackage

// ==== testbench.sv ====
`timescale 1ns/1ps
module testbench;
  import bsl_pkg::*;
  logic clock, rstn, slow_clock, divider_valid, bus_powered, aux_supply_3v3, load_ok, strap_level;
  logic flash_sclk, flash_cs_n, flash_data_out, flash_data_in, load_valid;
  logic internal_switch_en, external_switch_en, ports_enabled, legacy_sink, boot_done, in_boot;
  logic [7:0] boot_strap_divider_input, key, load_data;
  logic [15:0] slow_tick_count, tick_a;
  logic [31:0] cmd_word;
  bsl_db_mode_t db_mode;
  bsl_cfg_t fallback_cfg;
  int fail_count, total_checks, k;
  int corner [23] = '{0, 9, 10, 18, 19, 20, 28, 29, 30, 38, 40, 48, 50, 58, 60, 68, 70, 78, 80, 88, 89, 90, 100};
  int hold_r [6] = '{5, 25, 35, 45, 55, 65};
  bsl_db_mode_t mode_tab [2][10] = '{
    '{BSL_DB_NO_RESPONSE, BSL_DB_NO_RESPONSE, BSL_DB_CONTINUE, BSL_DB_RETRY_INT, BSL_DB_CONTINUE,
      BSL_DB_RETRY_EXT, BSL_DB_CONTINUE, BSL_DB_CONTINUE, BSL_DB_NO_RESPONSE, BSL_DB_CONTINUE},
    '{BSL_DB_NO_RESPONSE, BSL_DB_NO_RESPONSE, BSL_DB_WAIT_INT, BSL_DB_RETRY_INT, BSL_DB_WAIT_EXT,
      BSL_DB_RETRY_EXT, BSL_DB_CONTINUE, BSL_DB_CONTINUE, BSL_DB_CONTINUE, BSL_DB_CONTINUE}};
  bsl_cfg_t cfg_tab [2][10] = '{
    '{BSL_CFG_RESERVED, BSL_CFG_1, BSL_CFG_2, BSL_CFG_INFINITE, BSL_CFG_3, BSL_CFG_INFINITE, BSL_CFG_4,
      BSL_CFG_RESERVED, BSL_CFG_RESERVED, BSL_CFG_5},
    '{BSL_CFG_SAFE, BSL_CFG_SAFE, BSL_CFG_SAFE, BSL_CFG_INFINITE, BSL_CFG_SAFE, BSL_CFG_INFINITE,
      BSL_CFG_SAFE, BSL_CFG_SAFE, BSL_CFG_SAFE, BSL_CFG_SAFE}};

  bsl_loader bsl_loader_inst (.clock, .rstn, .slow_clock, .boot_strap_divider_input, .divider_valid,
    .bus_powered, .aux_supply_3v3, .flash_data_in, .image_last_byte(8'h00), .load_ok, .flash_sclk,
    .flash_cs_n, .flash_data_out, .load_data, .load_valid, .internal_switch_en, .external_switch_en,
    .ports_enabled, .legacy_sink, .boot_done, .in_boot, .db_mode, .fallback_cfg, .slow_tick_count);
  bsl_flash_model bsl_flash_model_inst (.flash_sclk, .flash_cs_n, .flash_data_out, .strap_level, .key,
    .flash_data_in, .cmd_word);

  // ----------
  // Clocks and shared tasks
  // ----------
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Link clock is offset so its edges never line up with the core clock
  initial begin
    slow_clock = 1'b0;
    #1.3;
    forever #3 slow_clock = ~slow_clock;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  function automatic int band(input int r);
    return (r >= 90) ? 9 : r / 10;
  endfunction
  function automatic logic [7:0] exp_byte(input int n);
    return key + 8'(n * 3);
  endfunction
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(negedge clock) if (rstn === 1'b1 && flash_cs_n === 1'b1) check(flash_sclk, 1'b0);
  // first command bit is the msb of the read code
  always @(negedge flash_cs_n) #1 check({flash_sclk, flash_data_out}, 2'h0);

  task automatic boot(input logic s, input int r, input logic bus, input logic aux);
    bsl_db_mode_t m;
    logic hold;
    m = mode_tab[s][band(r)];
    hold = bus && !aux && (m == BSL_DB_NO_RESPONSE || m == BSL_DB_WAIT_INT || m == BSL_DB_WAIT_EXT);
    @(negedge clock);
    rstn = 1'b0;
    divider_valid = 1'b0;
    strap_level = s;
    boot_strap_divider_input = 8'(r);
    bus_powered = bus;
    aux_supply_3v3 = aux;
    load_ok = 1'($urandom);
    repeat (3) @(negedge clock);
    rstn = 1'b1;
    @(negedge clock);
    check({flash_cs_n, flash_sclk, load_valid, internal_switch_en, external_switch_en, boot_done}, 6'h20);
    repeat (4) @(negedge clock);
    check(flash_cs_n, 1'b1);
    divider_valid = 1'b1;
    repeat (12) @(negedge clock);
    check(db_mode, m);
    check(fallback_cfg, cfg_tab[s][band(r)]);
    if (cfg_tab[s][band(r)] == BSL_CFG_INFINITE) check(in_boot, 1'b1);
    boot_strap_divider_input = 8'(100 - r);
    strap_level = ~s;
    repeat (4) @(negedge clock);
    check(db_mode, m);
    check(internal_switch_en, bus && (m == BSL_DB_WAIT_INT || m == BSL_DB_RETRY_INT));
    check(external_switch_en, bus && (m == BSL_DB_WAIT_EXT || m == BSL_DB_RETRY_EXT));
    check(flash_cs_n, hold);
    check({ports_enabled, legacy_sink}, 2'h0);
    if (hold) begin
      aux_supply_3v3 = 1'b1;
      repeat (10) @(negedge clock);
      check(flash_cs_n, 1'b0);
    end
  endtask

  // ----------
  // Test sequence
  // ----------
  initial begin
    rstn = 1'b0;
    divider_valid = 1'b0;
    strap_level = 1'b1;
    boot_strap_divider_input = 8'h00;
    bus_powered = 1'b0;
    aux_supply_3v3 = 1'b1;
    load_ok = 1'b0;
    key = 8'h00;
    fail_count = 0;
    total_checks = 0;
    void'($urandom(12));
    for (int s = 0; s < 2; s++) begin
      foreach (corner[i]) begin
        k = $urandom % 2;
        boot(1'(s), corner[i], 1'(k), !k || 1'($urandom));
      end
    end
    for (int i = 0; i < 20; i++) begin
      k = $urandom % 2;
      boot(1'($urandom), $urandom % 101, 1'(k), !k || 1'($urandom));
    end
    $display("test strap decode done");
    foreach (hold_r[i]) boot(1'b1, hold_r[i], 1'b1, 1'b0);
    $display("test supply hold done");
    key = 8'($urandom);
    boot(1'b0, 25, 1'b0, 1'b1);
    for (int n = 0; n < 4; n++) begin
      k = 0;
      while (load_valid !== 1'b1 && k < 600) begin
        @(negedge clock);
        k++;
      end
      check(k < 600, 1'b1);
      check(load_data, exp_byte(n));
      if (n == 0) check(cmd_word, 32'h03000000);
      @(negedge clock);
    end
    $display("test flash frame done");
    tick_a = slow_tick_count;
    repeat (60) @(negedge clock);
    check((slow_tick_count - tick_a) inside {[16'h005A:16'h006E]}, 1'b1);
    $display("test slow counter done");
    end_of_test();
  end
  initial begin
    #500000;
    fail_count++;
    end_of_test();
  end
endmodule
